// *** sac_defines.svh ***
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH

// ----------------------------------------------------------------------
// Conversion timing in operating-clock cycles per channel
// ----------------------------------------------------------------------
`define SAC_CYC_NOSH_8 6'd49
`define SAC_CYC_NOSH_10 6'd59
`define SAC_CYC_SH_8 6'd28
`define SAC_CYC_SH_10 6'd33
`define SAC_SAMP_NOSH 6'd2
`define SAC_SAMP_SH 6'd3

// ----------------------------------------------------------------------
// Resolution and approximation
// ----------------------------------------------------------------------
`define SAC_BITS_8 4'd8
`define SAC_BITS_10 4'd10
`define SAC_DAC_TOP 10'h200

// ----------------------------------------------------------------------
// Operating clock select {sel2, sel1, sel0} and divider limit; limit value is divide minus one
// ----------------------------------------------------------------------
`define SAC_DIVSEL_4 3'h0
`define SAC_DIVSEL_2 3'h1
`define SAC_DIVSEL_3 3'h2
`define SAC_DIVSEL_1 3'h3
`define SAC_DIVSEL_8 3'h4
`define SAC_DIVSEL_6 3'h6
`define SAC_DIVMAX_1 3'h0
`define SAC_DIVMAX_2 3'h1
`define SAC_DIVMAX_3 3'h2
`define SAC_DIVMAX_4 3'h3
`define SAC_DIVMAX_6 3'h5
`define SAC_DIVMAX_8 3'h7

// ----------------------------------------------------------------------
// Input multiplexer
// ----------------------------------------------------------------------
`define SAC_MUX_EXT0 6'h20
`define SAC_MUX_EXT1 6'h21
`define SAC_MULTI_PORT 2'h3
`define SAC_MULTI_LEN 5'h10

`endif

// *** sac_pkg.sv ***
`default_nettype none

package sac_pkg;

    typedef enum logic [2:0] {
        SAC_MODE_ONE = 3'h0,
        SAC_MODE_REP = 3'h1,
        SAC_MODE_SWP = 3'h2,
        SAC_MODE_RSW0 = 3'h3,
        SAC_MODE_RSW1 = 3'h4,
        SAC_MODE_MSWP = 3'h5,
        SAC_MODE_MRSW = 3'h6
    } sac_mode_e;

    typedef enum logic [1:0] {
        SAC_TRG_SW = 2'h0,
        SAC_TRG_EXT = 2'h1,
        SAC_TRG_HW = 2'h2
    } sac_trig_e;

    typedef enum logic [1:0] {SAC_IDLE, SAC_CONV, SAC_STORE} sac_state_e;

    typedef logic [7:0][9:0] sac_bank_t;

    typedef struct packed {
        sac_state_e st;
        logic [2:0] sync;
        logic ext_lvl;
        logic start_prev;
        logic [2:0] div_cnt;
        logic tick;
        logic [5:0] tcnt;
        logic [3:0] bits_left;
        logic r10;
        logic sh;
        logic [9:0] sar;
        logic [9:0] dac;
        logic [4:0] step;
        logic [5:0] mux;
        logic [2:0] idx;
        logic sample;
        logic done;
        logic ref_en;
        sac_bank_t res;
        logic res_stb;
        logic [2:0] res_idx;
        logic dma_req;
        logic busy;
    } sac_main_s;

endpackage

`default_nettype wire

// *** sac_fifo_if.sv ***
`default_nettype none

interface sac_fifo_if #(parameter int W = 13);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;

    modport fifo (
        input in_valid, in_data, out_ready,
        output in_ready, out_valid, out_data
    );
    modport user (
        output in_valid, in_data, out_ready,
        input in_ready, out_valid, out_data
    );
endinterface

`default_nettype wire

// *** sac_fifo.sv ***
`default_nettype none

module sac_fifo #(
    parameter int W = 13,
    parameter int D = 8,
    parameter int AW = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    sac_fifo_if.fifo port
);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } sac_fifo_s;

    sac_fifo_s q;
    sac_fifo_s n;
    logic push;
    logic pop;

    // ------------------------------------------------------------------
    // Storage and pointers
    // ------------------------------------------------------------------
    assign port.in_ready = (q.cnt != (AW + 1)'(D));
    assign port.out_valid = (q.cnt != '0);
    assign port.out_data = q.mem[q.rp];

    always_comb begin
        n = q;
        push = port.in_valid && port.in_ready;
        pop = port.out_valid && port.out_ready;
        if (push) begin
            n.mem[q.wp] = port.in_data;
            n.wp = (q.wp == AW'(D - 1)) ? '0 : q.wp + 1'b1;
        end
        if (pop) begin
            n.rp = (q.rp == AW'(D - 1)) ? '0 : q.rp + 1'b1;
        end
        if (push && !pop) begin
            n.cnt = q.cnt + 1'b1;
        end else if (pop && !push) begin
            n.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

endmodule // sac_fifo

`default_nettype wire

// *** sac_core.sv ***
`include "sac_defines.svh"
`default_nettype none

module sac_core
    import sac_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic NRST,
    input wire logic START_BIT,
    input wire logic [1:0] TRIG_SEL,
    input wire logic EXT_TRIG_PIN,
    input wire logic HW_TRIG,
    input wire logic [2:0] MODE,
    input wire logic RES_10BIT,
    input wire logic SH_EN,
    input wire logic [2:0] CLK_DIV_SEL,
    input wire logic DMA_MODE,
    input wire logic REF_CONNECT,
    input wire logic [1:0] PORT_SEL,
    input wire logic [2:0] CHAN_SEL,
    input wire logic [1:0] SWEEP_LEN,
    input wire logic [1:0] EXT_SEL,
    input wire logic COMPARE,
    input wire logic RESULT_HOLD,
    output logic [5:0] ANALOG_SEL,
    output logic SAMPLE_EN,
    output logic [9:0] DAC_CODE,
    output logic REF_LADDER_EN,
    output logic BUSY,
    output logic CONV_DONE,
    output sac_bank_t RESULT_REGS,
    output logic RESULT_STROBE,
    output logic [2:0] RESULT_INDEX,
    output logic DMA_REQ
);

    sac_main_s q;
    sac_main_s n;
    sac_fifo_if #(.W(13)) fif ();
    sac_bank_t bank_d;
    sac_mode_e mode;
    sac_trig_e tsel;
    logic [2:0] div_max;
    logic [5:0] total;
    logic [5:0] samp;
    logic [4:0] seq_len;
    logic ext_fall;
    logic trig;
    logic pop;
    logic [2:0] pop_idx;
    logic [9:0] pop_data;
    logic [9:0] result;
    logic [5:0] first_mux;
    logic [2:0] first_idx;

    // ------------------------------------------------------------------
    // Result buffer between core and result registers
    // ------------------------------------------------------------------
    sac_fifo #(
        .W(13),
        .D(8),
        .AW(3)
    ) u_fifo (
        .clk(REF_CLK),
        .rst_n(NRST),
        .port(fif.fifo)
    );

    assign fif.in_valid = (q.st == SAC_STORE);
    assign fif.in_data = {q.idx, result};
    assign fif.out_ready = !RESULT_HOLD;
    assign pop = fif.out_valid && fif.out_ready;
    assign pop_idx = fif.out_data[12:10];
    assign pop_data = fif.out_data[9:0];
    // 8-bit results are right aligned
    assign result = q.r10 ? q.sar : {2'b00, q.sar[9:2]};

    // ------------------------------------------------------------------
    // Per-register result bank update
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_bank
            assign bank_d[gi] = (pop && pop_idx == 3'(gi)) ?
                pop_data : q.res[gi];
        end
    endgenerate

    // ------------------------------------------------------------------
    // Configuration decode
    // ------------------------------------------------------------------
    assign mode = sac_mode_e'(MODE);
    assign tsel = sac_trig_e'(TRIG_SEL);

    always_comb begin
        case (CLK_DIV_SEL)
            `SAC_DIVSEL_1: div_max = `SAC_DIVMAX_1;
            `SAC_DIVSEL_2: div_max = `SAC_DIVMAX_2;
            `SAC_DIVSEL_3: div_max = `SAC_DIVMAX_3;
            `SAC_DIVSEL_4: div_max = `SAC_DIVMAX_4;
            `SAC_DIVSEL_6: div_max = `SAC_DIVMAX_6;
            `SAC_DIVSEL_8: div_max = `SAC_DIVMAX_8;
            default: div_max = `SAC_DIVMAX_8;
        endcase
    end

    always_comb begin
        if (q.sh) begin
            total = q.r10 ? `SAC_CYC_SH_10 : `SAC_CYC_SH_8;
            samp = `SAC_SAMP_SH;
        end else begin
            total = q.r10 ? `SAC_CYC_NOSH_10 : `SAC_CYC_NOSH_8;
            samp = `SAC_SAMP_NOSH;
        end
    end

    always_comb begin
        case (mode)
            SAC_MODE_SWP, SAC_MODE_RSW0:
                seq_len = {2'b00, SWEEP_LEN, 1'b0} + 5'd2;
            SAC_MODE_RSW1:
                seq_len = {2'b00, SWEEP_LEN, 1'b0} + {2'b00, SWEEP_LEN, 1'b0}
                    + 5'd2;
            SAC_MODE_MSWP, SAC_MODE_MRSW:
                seq_len = `SAC_MULTI_LEN;
            default:
                seq_len = 5'd1;
        endcase
    end

    // ------------------------------------------------------------------
    // Channel of a sequence step
    // ------------------------------------------------------------------
    function automatic logic [8:0] chan_at(input logic [4:0] s);
        logic [2:0] ch;
        logic [1:0] pt;
        logic [5:0] mx;
        ch = s[2:0];
        pt = PORT_SEL;
        mx = '0;
        case (mode)
            SAC_MODE_SWP, SAC_MODE_RSW0: begin
                mx = {1'b0, pt, ch};
            end
            SAC_MODE_RSW1: begin
                // Channel 0 alternates with each of the others
                ch = s[0] ? s[3:1] + 3'd1 : 3'd0;
                mx = {1'b0, pt, ch};
            end
            SAC_MODE_MSWP, SAC_MODE_MRSW: begin
                if (s[3]) begin
                    pt = `SAC_MULTI_PORT;
                end
                mx = {1'b0, pt, ch};
            end
            default: begin
                ch = CHAN_SEL;
                mx = {1'b0, pt, ch};
                if (EXT_SEL == 2'h1) begin
                    mx = `SAC_MUX_EXT0;
                    ch = 3'd0;
                end else if (EXT_SEL == 2'h2) begin
                    mx = `SAC_MUX_EXT1;
                    ch = 3'd1;
                end
            end
        endcase
        if (DMA_MODE) begin
            ch = 3'd0;
        end
        return {mx, ch};
    endfunction

    // A process, as the function reads configuration
    always_comb begin
        {first_mux, first_idx} = chan_at(5'd0);
    end

    // ------------------------------------------------------------------
    // Trigger detection
    // ------------------------------------------------------------------
    always_comb begin
        // Edge of the filtered pin level
        ext_fall = 1'b0;
        if (q.sync[1] == q.sync[2]) begin
            ext_fall = q.ext_lvl && !q.sync[2];
        end
        case (tsel)
            SAC_TRG_SW: trig = START_BIT && !q.start_prev;
            SAC_TRG_EXT: trig = START_BIT && ext_fall;
            SAC_TRG_HW: trig = START_BIT && HW_TRIG;
            default: trig = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Sequencer and successive approximation
    // ------------------------------------------------------------------
    always_comb begin
        n = q;
        // Pin synchroniser
        n.sync = {q.sync[1:0], EXT_TRIG_PIN};
        if (q.sync[1] == q.sync[2]) begin
            n.ext_lvl = q.sync[2];
        end
        n.start_prev = START_BIT;
        n.ref_en = REF_CONNECT;
        n.done = 1'b0;
        // Result bank follows buffer pops
        n.res = bank_d;
        n.res_stb = pop;
        n.dma_req = pop && DMA_MODE;
        if (pop) begin
            n.res_idx = pop_idx;
        end
        // Operating clock tick
        if (q.div_cnt >= div_max) begin
            n.div_cnt = '0;
            n.tick = 1'b1;
        end else begin
            n.div_cnt = q.div_cnt + 3'd1;
            n.tick = 1'b0;
        end
        case (q.st)
            SAC_IDLE: begin
                // Waits for a trigger
            end
            SAC_CONV: begin
                if (q.tick) begin
                    // One bit per tick after sampling
                    if (q.tcnt >= samp && q.bits_left != '0) begin
                        n.sar = COMPARE ? q.dac : q.sar;
                        n.bits_left = q.bits_left - 4'd1;
                        n.dac = n.sar;
                        if (q.bits_left > 4'd1) begin
                            n.dac[q.bits_left + 4'd6 + (q.r10 ? 4'd0 : 4'd2)
                                - 4'd8] = 1'b1;
                        end
                    end
                    // Last tick of the channel
                    if (q.tcnt == total - 6'd1) begin
                        n.st = SAC_STORE;
                    end else begin
                        n.tcnt = q.tcnt + 6'd1;
                    end
                end
            end
            SAC_STORE: begin
                // Waits here while the buffer is full
                if (fif.in_ready) begin
                    if (q.step == seq_len - 5'd1) begin
                        n.step = '0;
                        if (mode == SAC_MODE_ONE || mode == SAC_MODE_SWP ||
                            mode == SAC_MODE_MSWP || mode > SAC_MODE_MRSW)
                        begin
                            n.st = SAC_IDLE;
                            n.done = 1'b1;
                        end else begin
                            n.st = SAC_CONV;
                        end
                    end else begin
                        n.step = q.step + 5'd1;
                        n.st = SAC_CONV;
                    end
                    if (n.st == SAC_CONV) begin
                        {n.mux, n.idx} = chan_at(n.step);
                        n.tcnt = '0;
                        n.bits_left = RES_10BIT ? `SAC_BITS_10 : `SAC_BITS_8;
                        n.r10 = RES_10BIT;
                        n.sh = SH_EN;
                        n.sar = '0;
                        n.dac = `SAC_DAC_TOP;
                        n.div_cnt = '0;
                        n.tick = (div_max == `SAC_DIVMAX_1);
                    end
                end
            end
            default: begin
                n.st = SAC_IDLE;
            end
        endcase
        // Restart wins over store and stall
        if (trig) begin
            n.st = SAC_CONV;
            n.step = '0;
            n.mux = first_mux;
            n.idx = first_idx;
            n.tcnt = '0;
            n.bits_left = RES_10BIT ? `SAC_BITS_10 : `SAC_BITS_8;
            n.r10 = RES_10BIT;
            n.sh = SH_EN;
            n.sar = '0;
            n.dac = `SAC_DAC_TOP;
            n.div_cnt = '0;
            n.tick = (div_max == `SAC_DIVMAX_1);
        end else if (!START_BIT) begin
            n.st = SAC_IDLE;
        end
        // Registered flags
        n.sample = (n.st == SAC_CONV) && (n.tcnt < samp);
        n.busy = (n.st != SAC_IDLE);
    end

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign ANALOG_SEL = q.mux;
    assign SAMPLE_EN = q.sample;
    assign DAC_CODE = q.dac;
    assign REF_LADDER_EN = q.ref_en;
    assign BUSY = q.busy;
    assign CONV_DONE = q.done;
    assign RESULT_REGS = q.res;
    assign RESULT_STROBE = q.res_stb;
    assign RESULT_INDEX = q.res_idx;
    assign DMA_REQ = q.dma_req;

endmodule // sac_core

`default_nettype wire

// *** sac_fifo_note_unused.sv ***
`default_nettype none
`default_nettype wire

// *** sac_ain_model.sv ***
`default_nettype none

// ----------------------------------------------------------------------
// Analog inputs: each selection carries a fixed level
// ----------------------------------------------------------------------
module sac_ain_model (
    input wire logic [5:0] analog_sel,
    input wire logic [9:0] dac_code,
    output logic compare
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] level;

    // Level differs per port, channel and extended input
    assign level = {analog_sel, 4'hA};
    assign compare = level >= dac_code;
endmodule // sac_ain_model

`default_nettype wire

// *** sac_core_chk.sv ***
`default_nettype none

module sac_core_chk
    import sac_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic NRST,
    input wire logic START_BIT,
    input wire logic [1:0] TRIG_SEL,
    input wire logic EXT_TRIG_PIN,
    input wire logic HW_TRIG,
    input wire logic SH_EN,
    input wire logic [2:0] CLK_DIV_SEL,
    input wire logic DMA_MODE,
    input wire logic REF_CONNECT,
    input wire logic RESULT_HOLD,
    input wire logic SAMPLE_EN,
    input wire logic [9:0] DAC_CODE,
    input wire logic REF_LADDER_EN,
    input wire logic BUSY,
    input wire logic RESULT_STROBE,
    input wire logic [2:0] RESULT_INDEX,
    input wire logic DMA_REQ
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // Sequences and assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);

    sequence samp_2;
        SAMPLE_EN [*2] ##1 !SAMPLE_EN;
    endsequence
    sequence samp_3;
        SAMPLE_EN [*3] ##1 !SAMPLE_EN;
    endsequence
    sequence ext_fall;
        $fell(EXT_TRIG_PIN) && START_BIT && TRIG_SEL == 2'h1
        ##1 (!EXT_TRIG_PIN && START_BIT) [*4];
    endsequence
    sequence trial_start;
        SAMPLE_EN && DAC_CODE == 10'h200;
    endsequence

    AST_SAMP_NOSH: assert property (
        $rose(SAMPLE_EN) && CLK_DIV_SEL == 3'h3 && !SH_EN |-> samp_2)
        else $error("sampling without hold not two cycles");
    AST_SAMP_SH: assert property (
        $rose(SAMPLE_EN) && CLK_DIV_SEL == 3'h3 && SH_EN |-> samp_3)
        else $error("sampling with hold not three cycles");
    AST_SW_START: assert property (
        $rose(START_BIT) && TRIG_SEL == 2'h0 |=> BUSY ##0 trial_start)
        else $error("software start not taken");
    AST_EXT_START: assert property (
        ext_fall |-> ##[0:3] trial_start)
        else $error("external falling edge not taken");
    AST_HW_START: assert property (
        START_BIT && TRIG_SEL == 2'h2 && HW_TRIG |=> trial_start)
        else $error("timer request not taken");
    AST_START_LOW: assert property (
        !START_BIT |=> !BUSY)
        else $error("busy with start bit low");
    AST_DMA_IDX: assert property (
        RESULT_STROBE && DMA_MODE |-> RESULT_INDEX == 3'h0 && DMA_REQ)
        else $error("dma result not in first register");
    AST_DMA_PAIR: assert property (
        DMA_REQ |-> RESULT_STROBE && DMA_MODE)
        else $error("dma request without dma result");
    AST_REF: assert property (
        1'b1 |=> REF_LADDER_EN == $past(REF_CONNECT))
        else $error("ladder supply not following connect bit");
    AST_HOLD: assert property (
        RESULT_HOLD [*2] |=> !RESULT_STROBE)
        else $error("result delivered while held");
endmodule // sac_core_chk

bind sac_core sac_core_chk sac_core_chk_i (.REF_CLK, .NRST, .START_BIT,
    .TRIG_SEL, .EXT_TRIG_PIN, .HW_TRIG, .SH_EN, .CLK_DIV_SEL, .DMA_MODE,
    .REF_CONNECT, .RESULT_HOLD, .SAMPLE_EN, .DAC_CODE, .REF_LADDER_EN,
    .BUSY, .RESULT_STROBE, .RESULT_INDEX, .DMA_REQ);

`default_nettype wire

// *** tb_top.sv ***
`default_nettype none

module tb_top
    import sac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic REF_CLK = 1'b0;
    logic NRST = 1'b0;
    logic START_BIT = 1'b0;
    logic [1:0] TRIG_SEL = 2'h0;
    logic EXT_TRIG_PIN = 1'b1;
    logic HW_TRIG = 1'b0;
    logic [2:0] MODE = 3'h0;
    logic RES_10BIT = 1'b0;
    logic SH_EN = 1'b0;
    logic [2:0] CLK_DIV_SEL = 3'h3;
    logic DMA_MODE = 1'b0;
    logic REF_CONNECT = 1'b0;
    logic [1:0] PORT_SEL = 2'h0;
    logic [2:0] CHAN_SEL = 3'h0;
    logic [1:0] SWEEP_LEN = 2'h1;
    logic [1:0] EXT_SEL = 2'h0;
    logic RESULT_HOLD = 1'b0;
    logic COMPARE;
    logic [5:0] ANALOG_SEL;
    logic SAMPLE_EN;
    logic [9:0] DAC_CODE;
    logic REF_LADDER_EN;
    logic BUSY;
    logic CONV_DONE;
    sac_bank_t RESULT_REGS;
    logic RESULT_STROBE;
    logic [2:0] RESULT_INDEX;
    logic DMA_REQ;
    int error_cnt = 0;
    int checked = 0;

    sac_core sac_core_i (.REF_CLK, .NRST, .START_BIT, .TRIG_SEL,
        .EXT_TRIG_PIN, .HW_TRIG, .MODE, .RES_10BIT, .SH_EN, .CLK_DIV_SEL,
        .DMA_MODE, .REF_CONNECT, .PORT_SEL, .CHAN_SEL, .SWEEP_LEN, .EXT_SEL,
        .COMPARE, .RESULT_HOLD, .ANALOG_SEL, .SAMPLE_EN, .DAC_CODE,
        .REF_LADDER_EN, .BUSY, .CONV_DONE, .RESULT_REGS, .RESULT_STROBE,
        .RESULT_INDEX, .DMA_REQ);
    sac_ain_model sac_ain_model_i (.analog_sel(ANALOG_SEL),
        .dac_code(DAC_CODE), .compare(COMPARE));

    always #2 REF_CLK = ~REF_CLK;

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(string what, logic [9:0] exp, logic [9:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic cyc(int n);
        repeat (n) @(negedge REF_CLK);
    endtask

    function automatic logic [9:0] expv(logic [5:0] sel, logic r10);
        return r10 ? {sel, 4'hA} : {2'h0, sel, 2'h2};
    endfunction

    task automatic wait_stb(int n);
        for (int i = 0; i < n && RESULT_STROBE !== 1'b1; i++) cyc(1);
        chk("strobe", 10'h1, 10'(RESULT_STROBE));
    endtask

    task automatic set_cfg(logic [2:0] m, logic r10, logic sh,
            logic [2:0] dsel, logic dma, logic [1:0] trg);
        MODE = m;
        RES_10BIT = r10;
        SH_EN = sh;
        CLK_DIV_SEL = dsel;
        DMA_MODE = dma;
        TRIG_SEL = trg;
    endtask

    task automatic stop_test;
        $display("Comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_conv(logic r10, logic sh, logic [2:0] dsel, int dv,
            int ticks, logic [2:0] ch);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        set_cfg(3'h0, r10, sh, dsel, 1'b0, 2'h0);
        PORT_SEL = 2'h2;
        CHAN_SEL = ch;
        START_BIT = 1'b1;
        cyc(1);
        while (BUSY === 1'b1 && n < 3000) begin
            n++;
            done = done | (CONV_DONE === 1'b1);
            cyc(1);
        end
        done = done | (CONV_DONE === 1'b1);
        cyc(6);
        chk("done", 10'h1, 10'(done));
        chk("result", expv({3'h2, ch}, r10), RESULT_REGS[ch]);
        checked++;
        if (n < ticks * dv - 1 || n > ticks * dv + 3 * dv + 3) begin
            error_cnt++;
            $display("Error busy cycles expected %0d seen %0d", ticks * dv, n);
        end
        START_BIT = 1'b0;
        cyc(2);
        $display("Test conversion ended");
    endtask

    task automatic t_div;
        logic [2:0] sel [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
        int dv [6] = '{4, 2, 3, 1, 8, 6};
        for (int i = 0; i < 6; i++) begin
            t_conv(1'b0, 1'b1, sel[i], dv[i], 28, 3'(i));
        end
    endtask

    task automatic t_modes;
        int tab [7][4] = '{'{5, 0, 0, 0}, '{5, 5, 5, 5}, '{0, 1, 2, 3},
            '{0, 1, 2, 3}, '{0, 1, 0, 2}, '{0, 1, 2, 3}, '{0, 1, 2, 3}};
        PORT_SEL = 2'h1;
        CHAN_SEL = 3'h5;
        SWEEP_LEN = 2'h1;
        for (int m = 0; m < 7; m++) begin
            set_cfg(3'(m), 1'b0, 1'b0, 3'h3, 1'b0, 2'h0);
            START_BIT = 1'b1;
            for (int k = 0; k < (m == 0 ? 1 : 4); k++) begin
                wait_stb(300);
                chk("index", 10'(tab[m][k]), 10'(RESULT_INDEX));
                chk("value", expv({3'h1, 3'(tab[m][k])}, 1'b0),
                    RESULT_REGS[tab[m][k]]);
                cyc(1);
            end
            START_BIT = 1'b0;
            cyc(3);
        end
        $display("Test modes ended");
    endtask

    task automatic t_dma;
        set_cfg(3'h2, 1'b1, 1'b0, 3'h3, 1'b1, 2'h0);
        SWEEP_LEN = 2'h0;
        PORT_SEL = 2'h0;
        START_BIT = 1'b1;
        for (int k = 0; k < 2; k++) begin
            wait_stb(300);
            chk("dma index", 10'h0, 10'(RESULT_INDEX));
            chk("dma request", 10'h1, 10'(DMA_REQ));
            chk("dma value", expv(6'(k), 1'b1), RESULT_REGS[0]);
            cyc(1);
        end
        START_BIT = 1'b0;
        DMA_MODE = 1'b0;
        cyc(3);
        $display("Test dma ended");
    endtask

    task automatic t_trig;
        set_cfg(3'h0, 1'b0, 1'b0, 3'h3, 1'b0, 2'h1);
        EXT_TRIG_PIN = 1'b0;
        cyc(8);
        chk("pin without start", 10'h0, 10'(BUSY));
        EXT_TRIG_PIN = 1'b1;
        START_BIT = 1'b1;
        cyc(8);
        chk("start without pin", 10'h0, 10'(BUSY));
        EXT_TRIG_PIN = 1'b0;
        cyc(7);
        chk("pin start", 10'h1, 10'(BUSY));
        EXT_TRIG_PIN = 1'b1;
        cyc(70);
        START_BIT = 1'b0;
        TRIG_SEL = 2'h2;
        cyc(1);
        START_BIT = 1'b1;
        cyc(4);
        chk("timer idle", 10'h0, 10'(BUSY));
        HW_TRIG = 1'b1;
        cyc(1);
        HW_TRIG = 1'b0;
        chk("timer start", 10'h1, 10'(SAMPLE_EN));
        cyc(20);
        chk("mid conversion", 10'h0, 10'(SAMPLE_EN));
        HW_TRIG = 1'b1;
        cyc(1);
        HW_TRIG = 1'b0;
        chk("restart sample", 10'h1, 10'(SAMPLE_EN));
        chk("restart code", 10'h200, DAC_CODE);
        cyc(2);
        START_BIT = 1'b0;
        cyc(3);
        $display("Test triggers ended");
    endtask

    task automatic t_ext;
        for (int e = 1; e < 3; e++) begin
            set_cfg(3'h0, 1'b1, 1'b0, 3'h3, 1'b0, 2'h0);
            EXT_SEL = 2'(e);
            START_BIT = 1'b1;
            wait_stb(300);
            chk("ext index", 10'(e - 1), 10'(RESULT_INDEX));
            chk("ext value", expv(6'h1F + 6'(e), 1'b1),
                RESULT_REGS[e - 1]);
            START_BIT = 1'b0;
            cyc(3);
        end
        EXT_SEL = 2'h0;
        $display("Test extended inputs ended");
    endtask

    task automatic t_fifo;
        int seen;
        seen = 0;
        set_cfg(3'h1, 1'b0, 1'b0, 3'h3, 1'b0, 2'h0);
        RESULT_HOLD = 1'b1;
        START_BIT = 1'b1;
        repeat (600) begin
            cyc(1);
            if (RESULT_STROBE !== 1'b0) seen++;
        end
        chk("held strobes", 10'h0, 10'(seen));
        chk("stalled busy", 10'h1, 10'(BUSY));
        RESULT_HOLD = 1'b0;
        wait_stb(6);
        repeat (7) begin
            cyc(1);
            chk("drain strobe", 10'h1, 10'(RESULT_STROBE));
        end
        START_BIT = 1'b0;
        cyc(20);
        seen = 0;
        repeat (60) begin
            cyc(1);
            if (RESULT_STROBE !== 1'b0) seen++;
        end
        chk("empty strobes", 10'h0, 10'(seen));
        $display("Test buffer ended");
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        cyc(12);
        NRST = 1'b1;
        cyc(1);
        chk("reset flags", 10'h0, 10'({BUSY, SAMPLE_EN, RESULT_STROBE,
            DMA_REQ, CONV_DONE, REF_LADDER_EN}));
        chk("reset regs", 10'h0, 10'(|RESULT_REGS));
        REF_CONNECT = 1'b1;
        cyc(260);
        chk("ladder on", 10'h1, 10'(REF_LADDER_EN));
        t_conv(1'b0, 1'b0, 3'h3, 1, 49, 3'h3);
        t_conv(1'b1, 1'b0, 3'h3, 1, 59, 3'h7);
        t_conv(1'b1, 1'b1, 3'h1, 2, 33, 3'h6);
        t_div;
        t_modes;
        t_ext;
        t_dma;
        t_trig;
        t_fifo;
        REF_CONNECT = 1'b0;
        cyc(2);
        chk("ladder off", 10'h0, 10'(REF_LADDER_EN));
        stop_test;
    end

    // Ten times the expected run length
    initial begin
        cyc(40000);
        error_cnt++;
        $display("Error watchdog expired");
        stop_test;
    end
endmodule // tb_top

`default_nettype wire
